// file: src/rsq_defs.svh
// Offsets, field positions, reset values and counts of the reset sequencer.
// Assumes the including file sits under `default_nettype none.
`ifndef RSQ_DEFS_SVH
`define RSQ_DEFS_SVH

`define RSQ_ADDR_W        12
`define RSQ_OFF_CAUSE     12'h000
`define RSQ_OFF_DBGCTL    12'h004
`define RSQ_OFF_WAKEEN    12'h008
`define RSQ_OFF_PORTIN    12'h00C

`define RSQ_CAUSE_POR     0
`define RSQ_CAUSE_EXT     1
`define RSQ_CAUSE_WDT     2
`define RSQ_CAUSE_STOP    3
`define RSQ_CAUSE_W       4
`define RSQ_CAUSE_NONE    4'h0
`define RSQ_CAUSE_RST     4'h1
`define RSQ_DBG_RST_BIT   0

`define RSQ_WDT_DIV       8'h0A
`define RSQ_WDT_DIV_LAST  8'h09
`define RSQ_WDT_CYC_LAST  7'h41
`define RSQ_SYS_CYC_LAST  5'h0F
`define RSQ_EXT_CYC       3'h4
`define RSQ_PORT_W        8

`endif

// file: src/rsq_pkg.sv
// Types shared by the reset and stop recovery sequencer.
// Assumes nothing of its surroundings.
package rsq_pkg;
  typedef enum logic [2:0] {
    RSQ_RUN  = 3'b000,
    RSQ_HALT = 3'b001,
    RSQ_STOP = 3'b010,
    RSQ_HOLD = 3'b011,
    RSQ_WCNT = 3'b100,
    RSQ_SCNT = 3'b101,
    RSQ_PINW = 3'b110
  } rsq_state_e;
endpackage

// file: src/rsq_top.sv
// Reset and stop recovery sequencer with an APB register slave.
// Assumes all inputs but rstn_in are synchronous to clk_in; the watchdog oscillator
// is modelled by a divider tick, the system clock by clk_in with an enable.
// How it works
// - After supply rises, count 66 watchdog oscillator cycles.
// - Then count 16 system clock cycles.
// - Core stays in reset until both counts expire, then vector fetch.
// - A power-on reset sets the power-on cause bit afterwards.
// - Brown-out holds reset while low, then runs full sequence.
// - Brown-out in STOP is honoured only when its option is set.
// - Watchdog timeout resets in run or HALT when its option is 1.
// - A watchdog reset sets the watchdog cause bit.
// - External reset acts after 4 consecutive low system clock cycles.
// - Reset holds while pin low; ends at once on late release.
// - An external reset sets the external cause bit.
// - Debugger reset bit resets all but debugger, self clears, sets power-on.
// - STOP recovery holds reset 66 oscillator plus 16 system cycles.
// - STOP recovery alters only the cause register, no peripheral reset.
// - After STOP recovery the vector is fetched and stop cause set.
// - Watchdog timeout in STOP recovers and sets watchdog and stop bits.
// - Watchdog interrupt is raised after recovery when configured and enabled.
// - Either edge on an enabled wake pin starts recovery, sets stop.
// - Port input is frozen in STOP, captured at recovery end.
// - STOP halts crystal, clock, CPU; crystal input high, output low.
// - HALT stops CPU only; clocks and peripherals run.
// - HALT ends on interrupt, watchdog timeout, or any reset.
// - Supply faults override every other reset source.
`include "rsq_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module rsq_top (
  input  wire logic        clk_in,          // System clock, 100 MHz
  input  wire logic        rstn_in,         // Asynchronous reset, active low
  input  wire logic        psel_in,         // APB select
  input  wire logic        penable_in,      // APB enable
  input  wire logic        pwrite_in,       // APB direction
  input  wire logic [11:0] paddr_in,        // APB byte address
  input  wire logic [31:0] pwdata_in,       // APB write data
  output logic      [31:0] prdata_out,      // APB read data
  output logic             pready_out,      // APB ready
  output logic             pslverr_out,     // APB error, unmapped address
  input  wire logic        por_ok_in,       // Supply above power-on level
  input  wire logic        brownout_in,     // Brown-out monitor trip
  input  wire logic        ext_rstn_in,     // Filtered external reset pin
  input  wire logic        wdt_timeout_in,  // Watchdog timeout pulse
  input  wire logic        wdt_irq_mode_in, // Watchdog set for interrupt
  input  wire logic        irq_en_in,       // CPU interrupts enabled
  input  wire logic        irq_in,          // Any pending interrupt
  input  wire logic        stop_instr_in,   // CPU executed STOP
  input  wire logic        halt_instr_in,   // CPU executed HALT
  input  wire logic        wdt_rst_opt_in,  // Watchdog reset option
  input  wire logic        bo_stop_opt_in,  // Brown-out in STOP option
  input  wire logic [7:0]  gpio_in,         // Port pin levels
  output logic             core_rst_out,    // CPU held in reset
  output logic             periph_rst_out,  // Registers and peripherals reset
  output logic             ocd_rst_out,     // Debugger block reset
  output logic             cpu_run_out,     // CPU may execute
  output logic             sys_clk_en_out,  // System clock running
  output logic             xtal_stop_out,   // Crystal in high, out low
  output logic             fetch_vec_out,   // Pulse: fetch reset vector
  output logic             wdt_irq_out,     // Pulse: watchdog interrupt
  output logic [7:0]       port_in_out      // Port input data register
);

  logic                      rst_m;
  logic                      rst_n;
  rsq_pkg::rsq_state_e       state;
  rsq_pkg::rsq_state_e       next_state;
  logic [7:0]                div;
  logic                      tick;
  logic [6:0]                wcnt;
  logic [4:0]                scnt;
  logic [2:0]                extcnt;
  logic                      ext_act;
  logic                      kind_stop;
  logic                      kind_sup;
  logic                      next_kind_stop;
  logic                      next_kind_sup;
  logic [`RSQ_CAUSE_W-1:0]   pend;
  logic [`RSQ_CAUSE_W-1:0]   next_pend;
  logic [`RSQ_CAUSE_W-1:0]   cause;
  logic                      dbg_rst;
  logic [`RSQ_PORT_W-1:0]    wake_en;
  logic                      sup_bad;
  logic                      wake;
  logic                      done;
  logic                      wr_en;
  logic                      rd_en;
  logic                      mapped;

  function automatic logic in_rst(input rsq_pkg::rsq_state_e s);
    in_rst = (s == rsq_pkg::RSQ_HOLD) || (s == rsq_pkg::RSQ_WCNT) ||
             (s == rsq_pkg::RSQ_SCNT) || (s == rsq_pkg::RSQ_PINW);
  endfunction

  function automatic logic [`RSQ_CAUSE_W-1:0] bit4(input int pos);
    bit4 = `RSQ_CAUSE_NONE;
    bit4[pos] = 1'b1;
  endfunction

  // Reset release through two flops; only the second flop reads rst_m
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // Watchdog oscillator stand-in; it keeps running in STOP
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div <= 8'h00;
    end else if (div == `RSQ_WDT_DIV_LAST) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end
  assign tick = (div == `RSQ_WDT_DIV_LAST);

  // Supply faults; brown-out is masked in STOP unless opted in
  assign sup_bad = !por_ok_in ||
                   (brownout_in && (state != rsq_pkg::RSQ_STOP || bo_stop_opt_in));

  // External pin qualifier: counts consecutive low cycles
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      extcnt <= 3'h0;
    end else if (ext_rstn_in) begin
      extcnt <= 3'h0;
    end else if (extcnt != `RSQ_EXT_CYC) begin
      extcnt <= extcnt + 3'h1;
    end
  end
  assign ext_act = (extcnt == `RSQ_EXT_CYC);

  // Either edge against the frozen port image wakes from STOP
  assign wake = |((gpio_in ^ port_in_out) & wake_en);

  always_comb begin
    next_state     = state;
    next_kind_stop = kind_stop;
    next_kind_sup  = kind_sup;
    next_pend      = pend;
    done           = 1'b0;
    case (state)
      rsq_pkg::RSQ_RUN, rsq_pkg::RSQ_HALT: begin
        if (sup_bad) begin
          next_state     = rsq_pkg::RSQ_HOLD;
          next_kind_stop = 1'b0;
          next_kind_sup  = 1'b1;
          next_pend      = bit4(`RSQ_CAUSE_POR);
        end else if (dbg_rst) begin
          next_state     = rsq_pkg::RSQ_WCNT;
          next_kind_stop = 1'b0;
          next_kind_sup  = 1'b0;
          next_pend      = bit4(`RSQ_CAUSE_POR);
        end else if (ext_act) begin
          next_state     = rsq_pkg::RSQ_WCNT;
          next_kind_stop = 1'b0;
          next_kind_sup  = 1'b0;
          next_pend      = bit4(`RSQ_CAUSE_EXT);
        end else if (wdt_timeout_in && wdt_rst_opt_in) begin
          next_state     = rsq_pkg::RSQ_WCNT;
          next_kind_stop = 1'b0;
          next_kind_sup  = 1'b0;
          next_pend      = bit4(`RSQ_CAUSE_WDT);
        end else if (state == rsq_pkg::RSQ_HALT) begin
          if (irq_in || wdt_timeout_in) begin
            next_state = rsq_pkg::RSQ_RUN;
          end
        end else if (stop_instr_in) begin
          next_state = rsq_pkg::RSQ_STOP;
        end else if (halt_instr_in) begin
          next_state = rsq_pkg::RSQ_HALT;
        end
      end
      rsq_pkg::RSQ_STOP: begin
        if (sup_bad) begin
          next_state     = rsq_pkg::RSQ_HOLD;
          next_kind_stop = 1'b0;
          next_kind_sup  = 1'b1;
          next_pend      = bit4(`RSQ_CAUSE_POR);
        end else if (ext_act) begin
          next_state     = rsq_pkg::RSQ_WCNT;
          next_kind_stop = 1'b0;
          next_kind_sup  = 1'b0;
          next_pend      = bit4(`RSQ_CAUSE_EXT);
        end else if (wdt_timeout_in) begin
          next_state     = rsq_pkg::RSQ_WCNT;
          next_kind_stop = 1'b1;
          next_kind_sup  = 1'b0;
          next_pend      = bit4(`RSQ_CAUSE_WDT) | bit4(`RSQ_CAUSE_STOP);
        end else if (wake) begin
          next_state     = rsq_pkg::RSQ_WCNT;
          next_kind_stop = 1'b1;
          next_kind_sup  = 1'b0;
          next_pend      = bit4(`RSQ_CAUSE_STOP);
        end
      end
      rsq_pkg::RSQ_HOLD: begin
        if (!sup_bad) begin
          next_state = rsq_pkg::RSQ_WCNT;
        end
      end
      rsq_pkg::RSQ_WCNT: begin
        if (sup_bad) begin
          next_state     = rsq_pkg::RSQ_HOLD;
          next_kind_stop = 1'b0;
          next_kind_sup  = 1'b1;
          next_pend      = bit4(`RSQ_CAUSE_POR);
        end else if (tick && wcnt == `RSQ_WDT_CYC_LAST) begin
          next_state = rsq_pkg::RSQ_SCNT;
        end
      end
      rsq_pkg::RSQ_SCNT: begin
        if (sup_bad) begin
          next_state     = rsq_pkg::RSQ_HOLD;
          next_kind_stop = 1'b0;
          next_kind_sup  = 1'b1;
          next_pend      = bit4(`RSQ_CAUSE_POR);
        end else if (scnt == `RSQ_SYS_CYC_LAST) begin
          if (!ext_rstn_in) begin
            next_state = rsq_pkg::RSQ_PINW;
          end else begin
            next_state = rsq_pkg::RSQ_RUN;
            done       = 1'b1;
          end
        end
      end
      rsq_pkg::RSQ_PINW: begin
        if (sup_bad) begin
          next_state     = rsq_pkg::RSQ_HOLD;
          next_kind_stop = 1'b0;
          next_kind_sup  = 1'b1;
          next_pend      = bit4(`RSQ_CAUSE_POR);
        end else if (ext_rstn_in) begin
          next_state = rsq_pkg::RSQ_RUN;
          done       = 1'b1;
        end
      end
      default: begin
        next_state = rsq_pkg::RSQ_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state     <= rsq_pkg::RSQ_HOLD;
      kind_stop <= 1'b0;
      kind_sup  <= 1'b1;
      pend      <= `RSQ_CAUSE_RST;
    end else begin
      state     <= next_state;
      kind_stop <= next_kind_stop;
      kind_sup  <= next_kind_sup;
      pend      <= next_pend;
    end
  end

  // Both counters restart whenever their phase is entered
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wcnt <= 7'h00;
      scnt <= 5'h00;
    end else begin
      if (state != rsq_pkg::RSQ_WCNT) begin
        wcnt <= 7'h00;
      end else if (tick) begin
        wcnt <= wcnt + 7'h01;
      end
      if (state != rsq_pkg::RSQ_SCNT) begin
        scnt <= 5'h00;
      end else begin
        scnt <= scnt + 5'h01;
      end
    end
  end

  // Outputs follow the next state so they stand in step with it
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      core_rst_out   <= 1'b1;
      periph_rst_out <= 1'b1;
      ocd_rst_out    <= 1'b1;
      cpu_run_out    <= 1'b0;
      sys_clk_en_out <= 1'b0;
      xtal_stop_out  <= 1'b0;
      fetch_vec_out  <= 1'b0;
      wdt_irq_out    <= 1'b0;
    end else begin
      core_rst_out   <= in_rst(next_state);
      periph_rst_out <= in_rst(next_state) && !next_kind_stop;
      ocd_rst_out    <= in_rst(next_state) && next_kind_sup;
      cpu_run_out    <= (next_state == rsq_pkg::RSQ_RUN);
      sys_clk_en_out <= (next_state != rsq_pkg::RSQ_STOP) &&
                        (next_state != rsq_pkg::RSQ_HOLD) &&
                        (next_state != rsq_pkg::RSQ_WCNT);
      xtal_stop_out  <= (next_state == rsq_pkg::RSQ_STOP);
      fetch_vec_out  <= done;
      wdt_irq_out    <= done && kind_stop && pend[`RSQ_CAUSE_WDT] &&
                        wdt_irq_mode_in && irq_en_in;
    end
  end

  // Port image freezes from STOP entry until recovery completes
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      port_in_out <= 8'h00;
    end else if (next_state == rsq_pkg::RSQ_RUN ||
                 next_state == rsq_pkg::RSQ_HALT) begin
      port_in_out <= gpio_in;
    end
  end

  assign mapped = (paddr_in == `RSQ_OFF_CAUSE) || (paddr_in == `RSQ_OFF_DBGCTL) ||
                  (paddr_in == `RSQ_OFF_WAKEEN) || (paddr_in == `RSQ_OFF_PORTIN);
  assign wr_en  = psel_in && penable_in && pready_out && pwrite_in && mapped;
  assign rd_en  = psel_in && penable_in && !pready_out && !pwrite_in;

  // Cause bits: replaced at reset end, write one clears, set wins
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cause <= `RSQ_CAUSE_NONE;
    end else if (done) begin
      cause <= pend;
    end else if (wr_en && paddr_in == `RSQ_OFF_CAUSE) begin
      cause <= cause & ~pwdata_in[`RSQ_CAUSE_W-1:0];
    end
  end

  // Debugger reset bit clears as the sequence it asked for begins
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      dbg_rst <= 1'b0;
      wake_en <= 8'h00;
    end else begin
      if (in_rst(state)) begin
        dbg_rst <= 1'b0;
      end else if (wr_en && paddr_in == `RSQ_OFF_DBGCTL) begin
        dbg_rst <= pwdata_in[`RSQ_DBG_RST_BIT];
      end
      if (wr_en && paddr_in == `RSQ_OFF_WAKEEN && !periph_rst_out) begin
        wake_en <= pwdata_in[`RSQ_PORT_W-1:0];
      end
    end
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= psel_in && penable_in && !pready_out;
      pslverr_out <= psel_in && penable_in && !pready_out && !mapped;
      prdata_out  <= 32'h0000_0000;
      if (rd_en) begin
        case (paddr_in)
          `RSQ_OFF_CAUSE: begin
            prdata_out <= {25'h0, state, cause};
          end
          `RSQ_OFF_DBGCTL: begin
            prdata_out <= {31'h0, dbg_rst};
          end
          `RSQ_OFF_WAKEEN: begin
            prdata_out <= {24'h0, wake_en};
          end
          `RSQ_OFF_PORTIN: begin
            prdata_out <= {24'h0, port_in_out};
          end
          default: begin
            prdata_out <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  property p_wcnt_done;
    (state == rsq_pkg::RSQ_SCNT && $past(state) == rsq_pkg::RSQ_WCNT)
      |-> $past(wcnt) == `RSQ_WDT_CYC_LAST;
  endproperty
  a_wcnt_done: assert property (p_wcnt_done) else $error("short oscillator count");

  property p_scnt_done;
    (state == rsq_pkg::RSQ_SCNT && scnt == `RSQ_SYS_CYC_LAST && !sup_bad)
      |=> state != rsq_pkg::RSQ_SCNT;
  endproperty
  a_scnt_done: assert property (p_scnt_done) else $error("clock count overran");

  property p_core_held;
    (state == rsq_pkg::RSQ_WCNT) |-> core_rst_out ##1 core_rst_out;
  endproperty
  a_core_held: assert property (p_core_held) else $error("core left reset early");

  property p_supply;
    sup_bad |=> state == rsq_pkg::RSQ_HOLD ##1 core_rst_out;
  endproperty
  a_supply: assert property (p_supply) else $error("supply fault ignored");

  property p_ext_filter;
    $rose(ext_act) |-> $past(ext_rstn_in) == 1'b0 && $past(ext_rstn_in, 2) == 1'b0 &&
                        $past(ext_rstn_in, 3) == 1'b0 && $past(ext_rstn_in, 4) == 1'b0;
  endproperty
  a_ext_filter: assert property (p_ext_filter) else $error("pin qualified too soon");

  property p_pin_release;
    (state == rsq_pkg::RSQ_PINW && ext_rstn_in && !sup_bad)
      |=> state == rsq_pkg::RSQ_RUN && !core_rst_out && fetch_vec_out;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("late release");

  property p_stop_cause;
    (done && kind_stop) |=> cause[`RSQ_CAUSE_STOP] && !periph_rst_out;
  endproperty
  a_stop_cause: assert property (p_stop_cause) else $error("stop cause lost");

  property p_stop_keep;
    (core_rst_out && kind_stop) |-> !periph_rst_out;
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("recovery reset periph");

  property p_stop_clk;
    (state == rsq_pkg::RSQ_STOP && $past(state) == rsq_pkg::RSQ_STOP)
      |-> xtal_stop_out && !sys_clk_en_out && !cpu_run_out;
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("clock ran in STOP");

  property p_dbg_clear;
    (state == rsq_pkg::RSQ_WCNT) |=> !dbg_rst;
  endproperty
  a_dbg_clear: assert property (p_dbg_clear) else $error("debug bit stuck");

  c_por_done: cover property (done && kind_sup);
  c_wake: cover property (state == rsq_pkg::RSQ_STOP ##1 wake);
  c_pinw: cover property (state == rsq_pkg::RSQ_PINW ##1 state == rsq_pkg::RSQ_RUN);
  c_halt_exit: cover property (state == rsq_pkg::RSQ_HALT ##1 state == rsq_pkg::RSQ_RUN);

endmodule

`default_nettype wire

// file: tb/rsq_partner.sv
// Far-side model: brown-out monitor, external reset pin, watchdog, port pins.
// Assumes the bench calls its tasks; every change lands right after an edge.
`timescale 1ns/1ns
`default_nettype none
module rsq_partner (
  input  wire logic       clk_in,       // System clock
  output logic            por_ok_out,   // Supply above power-on level
  output logic            bo_out,       // Brown-out trip
  output logic            ext_rstn_out, // External reset pin, active low
  output logic            wdt_to_out,   // Watchdog timeout pulse
  output logic [7:0]      pins_out      // Port pin levels
);
  initial begin
    por_ok_out = 1'b1;
    bo_out = 1'b0;
    ext_rstn_out = 1'b1;
    wdt_to_out = 1'b0;
    pins_out = 8'h00;
  end
  // Pin held low for n whole cycles; fewer than 4 must be ignored
  task automatic ext_low(input int n);
    @(posedge clk_in);
    ext_rstn_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    ext_rstn_out <= 1'b1;
  endtask
  task automatic wdt_pulse();
    @(posedge clk_in);
    wdt_to_out <= 1'b1;
    @(posedge clk_in);
    wdt_to_out <= 1'b0;
  endtask
  task automatic supply(input logic ok);
    @(posedge clk_in);
    por_ok_out <= ok;
  endtask
  task automatic bo(input logic on);
    @(posedge clk_in);
    bo_out <= on;
  endtask
  task automatic pins(input logic [7:0] v);
    @(posedge clk_in);
    pins_out <= v;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Bench for the reset and stop recovery sequencer: APB master and scenarios.
// Assumes the far-side model drives supply, reset pin, watchdog and pins.
`timescale 1ns/1ns
`default_nettype none
`include "rsq_defs.svh"
module tb_top;
  logic        clk_in, rstn_in;
  logic        psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rdata;
  logic        pready_out, pslverr_out, rerr, irq_seen;
  logic        wdt_irq_mode_in, irq_en_in, irq_in;
  logic        stop_instr_in, halt_instr_in;
  logic        wdt_rst_opt_in, bo_stop_opt_in;
  logic        por_ok_in, brownout_in, ext_rstn_in, wdt_timeout_in;
  logic [7:0]  gpio_in, port_in_out;
  logic        core_rst_out, periph_rst_out, ocd_rst_out, cpu_run_out;
  logic        sys_clk_en_out, xtal_stop_out, fetch_vec_out, wdt_irq_out;
  int          err_count = 0, n_checks = 0, n;

  rsq_top i_dut (
    .clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .por_ok_in, .brownout_in, .ext_rstn_in,
    .wdt_timeout_in, .wdt_irq_mode_in, .irq_en_in, .irq_in, .stop_instr_in,
    .halt_instr_in, .wdt_rst_opt_in, .bo_stop_opt_in, .gpio_in, .core_rst_out,
    .periph_rst_out, .ocd_rst_out, .cpu_run_out, .sys_clk_en_out, .xtal_stop_out,
    .fetch_vec_out, .wdt_irq_out, .port_in_out
  );
  rsq_partner i_far (
    .clk_in, .por_ok_out(por_ok_in), .bo_out(brownout_in), .ext_rstn_out(ext_rstn_in),
    .wdt_to_out(wdt_timeout_in), .pins_out(gpio_in)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic print_verdict();
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rdata = prdata_out;
    rerr  = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic cause(input logic [31:0] e);
    apb(1'b0, `RSQ_OFF_CAUSE, 32'h0);
    chk(rdata, e);
  endtask
  // Oscillator tick phase is free, so the length is judged inside a window
  task automatic wait_fetch(input int lo, input int hi);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (fetch_vec_out !== 1'b1 && n < 3000);
    irq_seen = wdt_irq_out;
    chk(core_rst_out, 1'b0);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic cpu(input logic stop);
    @(posedge clk_in);
    stop_instr_in <= stop;
    halt_instr_in <= !stop;
    @(posedge clk_in);
    stop_instr_in <= 1'b0;
    halt_instr_in <= 1'b0;
  endtask

  task automatic t_apb();
    apb(1'b1, `RSQ_OFF_CAUSE, 32'hF);
    cause(32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(rerr, 1'b1);
    chk(rdata, 32'h0);
  endtask
  task automatic t_ext();
    i_far.ext_low(3);
    repeat (6) @(posedge clk_in);
    chk(core_rst_out, 1'b0);
    i_far.ext_low(4);
    wait_fetch(655, 690);
    cause(32'h2);
    i_far.ext_low(900);
    wait_fetch(1, 3);
    cause(32'h2);
  endtask
  task automatic t_wdt();
    wdt_rst_opt_in <= 1'b0;
    i_far.wdt_pulse();
    repeat (4) @(posedge clk_in);
    chk(core_rst_out, 1'b0);
    wdt_rst_opt_in <= 1'b1;
    i_far.wdt_pulse();
    wait_fetch(655, 690);
    cause(32'h4);
  endtask
  task automatic t_dbg();
    apb(1'b1, `RSQ_OFF_DBGCTL, 32'h1);
    repeat (2) @(posedge clk_in);
    chk(core_rst_out, 1'b1);
    chk(ocd_rst_out, 1'b0);
    wait_fetch(650, 690);
    cause(32'h1);
    apb(1'b0, `RSQ_OFF_DBGCTL, 32'h0);
    chk(rdata, 32'h0);
  endtask
  task automatic t_bo();
    fork
      i_far.ext_low(20);
    join_none
    i_far.bo(1'b1);
    repeat (50) @(posedge clk_in);
    chk(core_rst_out, 1'b1);
    chk(ocd_rst_out, 1'b1);
    i_far.bo(1'b0);
    wait_fetch(655, 690);
    cause(32'h1);
  endtask
  task automatic t_stop_gpio();
    apb(1'b1, `RSQ_OFF_WAKEEN, 32'h1);
    cpu(1'b1);
    repeat (3) @(posedge clk_in);
    chk(xtal_stop_out, 1'b1);
    chk(sys_clk_en_out, 1'b0);
    i_far.pins(8'h02);
    repeat (3) @(posedge clk_in);
    chk(xtal_stop_out, 1'b1);
    i_far.pins(8'h03);
    repeat (3) @(posedge clk_in);
    chk(periph_rst_out, 1'b0);
    chk(port_in_out, 8'h00);
    wait_fetch(645, 690);
    chk(irq_seen, 1'b0);
    cause(32'h8);
    chk(port_in_out, 8'h03);
  endtask
  task automatic t_stop_wdt();
    wdt_irq_mode_in <= 1'b1;
    irq_en_in <= 1'b1;
    cpu(1'b1);
    i_far.bo(1'b1);
    repeat (4) @(posedge clk_in);
    chk(xtal_stop_out, 1'b1);
    i_far.bo(1'b0);
    i_far.wdt_pulse();
    wait_fetch(650, 690);
    chk(irq_seen, 1'b1);
    cause(32'hC);
  endtask
  // Brown-out honoured in STOP once opted in, then a plain supply drop
  task automatic t_stop_bo();
    bo_stop_opt_in <= 1'b1;
    cpu(1'b1);
    i_far.bo(1'b1);
    repeat (3) @(posedge clk_in);
    chk(core_rst_out, 1'b1);
    chk(ocd_rst_out, 1'b1);
    i_far.bo(1'b0);
    wait_fetch(655, 690);
    cause(32'h1);
    i_far.supply(1'b0);
    repeat (4) @(posedge clk_in);
    chk(core_rst_out, 1'b1);
    i_far.supply(1'b1);
    wait_fetch(655, 690);
    cause(32'h1);
  endtask
  task automatic t_halt();
    cpu(1'b0);
    repeat (3) @(posedge clk_in);
    chk(cpu_run_out, 1'b0);
    chk(sys_clk_en_out, 1'b1);
    irq_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(cpu_run_out, 1'b1);
    irq_in <= 1'b0;
    wdt_rst_opt_in <= 1'b0;
    cpu(1'b0);
    @(posedge clk_in);
    chk(cpu_run_out, 1'b0);
    i_far.wdt_pulse();
    repeat (3) @(posedge clk_in);
    chk(cpu_run_out, 1'b1);
  endtask

  // Longest path is nine full reset sequences plus the long pin hold
  initial begin
    repeat (15000) @(posedge clk_in);
    err_count++;
    print_verdict();
  end
  initial begin
    rstn_in         = 1'b0;
    psel_in         = 1'b0;
    penable_in      = 1'b0;
    pwrite_in       = 1'b0;
    paddr_in        = 12'h000;
    pwdata_in       = 32'h0;
    wdt_irq_mode_in = 1'b0;
    irq_en_in       = 1'b0;
    irq_in          = 1'b0;
    stop_instr_in   = 1'b0;
    halt_instr_in   = 1'b0;
    wdt_rst_opt_in  = 1'b1;
    bo_stop_opt_in  = 1'b0;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    wait_fetch(655, 690);
    cause(32'h1);
    t_apb();
    t_ext();
    t_wdt();
    t_dbg();
    t_bo();
    t_stop_gpio();
    t_stop_wdt();
    t_stop_bo();
    t_halt();
    print_verdict();
  end
endmodule
`default_nettype wire
